/* design/sgcr_pkg.sv */
package sgcr_pkg;

	// ------------------------------------------------------------
	// Geometry and timing
	// ------------------------------------------------------------
	localparam int          NUM_CH    = 4;
	localparam int          SLOTS     = NUM_CH;
	localparam int          AVG_DEPTH = 1024;
	localparam int          NT_DEPTH  = 64;
	localparam int          CLK_NS    = 100;
	localparam int          US_NS     = 1000;
	localparam int          RAMP_US   = 200;
	localparam int          US_CYC_I  = US_NS / CLK_NS;
	localparam int          RAMP_CY_I = RAMP_US * US_CYC_I;
	localparam logic [3:0]  US_LAST   = 4'(US_CYC_I - 1);
	localparam logic [10:0] RAMP_LAST = 11'(RAMP_CY_I - 1);

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [9:0] OFS_CTRL  [NUM_CH] =
		'{10'h002, 10'h006, 10'h00A, 10'h00E};
	localparam logic [9:0] OFS_VALUE [NUM_CH] =
		'{10'h004, 10'h00C, 10'h014, 10'h01C};
	localparam logic [9:0] OFS_FLAGS [NUM_CH] =
		'{10'h021, 10'h023, 10'h025, 10'h027};
	localparam logic [9:0] OFS_NOTCH [NUM_CH] =
		'{10'h202, 10'h242, 10'h282, 10'h2C2};
	localparam logic [9:0] OFS_CONV  = 10'h101;
	localparam logic [9:0] OFS_STAMP = 10'h10C;

	// ------------------------------------------------------------
	// Field layout and codes
	// ------------------------------------------------------------
	localparam logic [15:0] CTRL_MASK  = 16'h7DFF;
	localparam logic [15:0] NOTCH_MASK = 16'h7000;
	localparam logic [15:0] WORD_RST   = 16'h0000;
	localparam int FACTOR_LSB = 0;
	localparam int AVG_LSB    = 3;
	localparam int NOTCH_EN   = 8;
	localparam int LP_MODE_LSB = 10;
	localparam int LP_LVL_LSB = 12;
	localparam int ATT_LSB    = 12;
	localparam int FREQ_BIT   = 14;
	localparam logic [1:0] LP_FIRST = 2'h1;
	localparam logic [5:0] NT_DLY_50 = 6'h32;
	localparam logic [5:0] NT_DLY_60 = 6'h2A;
	localparam logic [1:0] LAST_CH   = 2'h3;

	localparam logic signed [23:0] VALID_MAX = 24'sh7FFFFE;
	localparam logic signed [23:0] VALID_MIN = -24'sh7FFFFE;
	localparam logic signed [23:0] RAW_OVER  = 24'sh7FFFFF;
	localparam logic [31:0] CODE_OVER  = 32'h007FFFFF;
	localparam logic [31:0] CODE_UNDER = 32'hFF800001;
	localparam logic [31:0] CODE_INVAL = 32'hFF800000;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [9:0]  addr;
		logic [31:0] wdata;
	} sgcr_req_s;

	typedef struct packed {
		logic [1:0]        chan;
		logic signed [23:0] raw;
		logic              err;
		logic [31:0]       stamp;
	} sgcr_entry_s;

	// Averaging length per code; reserved codes stay at 1000
	function automatic logic [9:0] sgcr_avg_len(input logic [4:0] code);
		unique case (code)
			5'h00: return 10'h001;
			5'h01: return 10'h002;
			5'h02: return 10'h004;
			5'h03: return 10'h005;
			5'h04: return 10'h00A;
			5'h05: return 10'h014;
			5'h06: return 10'h019;
			5'h07: return 10'h032;
			5'h08: return 10'h053;
			5'h09: return 10'h064;
			5'h0A: return 10'h07D;
			5'h0B: return 10'h0A7;
			5'h0C: return 10'h0C8;
			5'h0D: return 10'h0FA;
			5'h0E: return 10'h12C;
			5'h0F: return 10'h1F4;
			default: return 10'h3E8;
		endcase
	endfunction

endpackage

/* design/sgcr_readout.sv */
// Summary of operation
// (R1) Bits 0-2 select sensor factor, 256 to 2
// (R2) Bits 3-7 select moving average length
// (R3) Reserved averaging codes never exceed 1000 samples
// (R4) Bit 8 inserts notch stage, default bypassed
// (R5) Bits 10-11 low-pass mode, only 01 active
// (R6) Bits 12-14 give low-pass level minus one
// (R7) Low-pass adds shifted difference; disabled means level 0
// (R8) Notch word bits 12-13 pick attenuation
// (R9) Notch word bit 14 picks 50/60 Hz
// (R10) Valid range plus overflow/open-line code 8388607
// (R11) Underflow -8388607, invalid -8388608
// (R12) Flag 0 follows I/O supply fault
// (R13) Flag 1 follows excitation overcurrent
// (R14) Flag 4 unconfigured; flag 5 forces invalid code
// (R15) Flag 6 marks overflow or underflow input code
// (R16) Flag 7 while average not at length
// (R17) Length steps one per 200 us
// (R18) Channels converted one at a time
// (R19) Counter bits 0-1 hold last channel
// (R20) Counter bits 2-7 count completed conversion cycles
// (R21) Time stamp of last channel's conversion
// (R22) Four analog logical slots presented
// (R23) Reserved control bits ignored
// (R24) Filters start disabled; channels independent
`timescale 1ns/1ps
`default_nettype none
module sgcr_readout
	import sgcr_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire sgcr_req_s             reg_req,
	output logic [31:0]                reg_rdata,
	output logic                       reg_rvalid,
	input  wire logic                  adc_valid,
	output logic                       adc_ready,
	input  wire logic [1:0]            adc_channel,
	input  wire logic signed [23:0]    adc_raw,
	input  wire logic                  adc_checksum_ok,
	input  wire logic                  adc_configured,
	input  wire logic                  io_supply_fault,
	input  wire logic                  sensor_supply_fault,
	input  wire logic                  excitation_overcurrent,
	output logic [NUM_CH-1:0][2:0]     gauge_factor,
	output logic [NUM_CH-1:0][1:0]     notch_atten
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [NUM_CH-1:0][15:0]  ctrl;
		logic [NUM_CH-1:0][15:0]  notch;
		logic [NUM_CH-1:0][31:0]  value;
		logic [NUM_CH-1:0][2:0]   flags;
		logic [NUM_CH-1:0][9:0]   cur_len;
		logic [NUM_CH-1:0][33:0]  sum;
		logic [NUM_CH-1:0][23:0]  lp_y;
		logic [NUM_CH-1:0]        ramp_due;
		logic [NUM_CH-1:0][9:0]   avg_wp;
		logic [NUM_CH-1:0][5:0]   nt_wp;
		logic [1:0]               last_ch;
		logic [5:0]               cycles;
		logic [31:0]              stamp;
		logic [31:0]              us_time;
		logic [3:0]               us_div;
		logic [10:0]              ramp_div;
		sgcr_entry_s [1:0]        fifo;
		logic [1:0]               fifo_cnt;
		logic [31:0]              rdata;
		logic                     rvalid;
	} sgcr_state_s;

	sgcr_state_s st_r;
	sgcr_state_s st_nxt;

	logic signed [23:0] avg_mem [NUM_CH][AVG_DEPTH];
	logic signed [23:0] nt_mem  [NUM_CH][NT_DEPTH];

	sgcr_entry_s        head;
	logic [1:0]         ch;
	logic               pop;
	logic               push;
	logic [15:0]        cw;
	logic [15:0]        nw;
	logic [5:0]         nt_idx;
	logic signed [23:0] nt_old;
	logic signed [24:0] nt_sum;
	logic signed [23:0] xn;
	logic [9:0]         target;
	logic [9:0]         cur;
	logic [9:0]         cur_new;
	logic [9:0]         av_i1;
	logic [9:0]         av_i2;
	logic signed [33:0] sum_new;
	logic signed [33:0] avg_q;
	logic signed [23:0] avg_out;
	logic [3:0]         lp_lvl;
	logic signed [24:0] lp_diff;
	logic signed [24:0] lp_sh;
	logic signed [24:0] lp_add;
	logic signed [23:0] lp_out;
	logic signed [23:0] res;
	logic               over;
	logic               under;
	logic               mem_we;
	logic               us_tick;
	logic               ramp_tick;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_nxt    = st_r;
		head      = st_r.fifo[0];
		ch        = head.chan;
		cw        = st_r.ctrl[ch];
		nw        = st_r.notch[ch];
		push      = adc_valid && adc_ready;
		pop       = (st_r.fifo_cnt != 2'h0) && !reg_req.wr;
		mem_we    = pop;
		us_tick   = st_r.us_div == US_LAST;
		ramp_tick = st_r.ramp_div == RAMP_LAST;

		// Microsecond time base and ramp divider
		st_nxt.us_div   = us_tick ? 4'h0 : 4'(st_r.us_div + 4'h1);
		st_nxt.ramp_div = ramp_tick ? 11'h000
			: 11'(st_r.ramp_div + 11'h001);                   // (R17)
		if (us_tick)
			st_nxt.us_time = 32'(st_r.us_time + 32'h1);

		// Notch stage: comb over half the mains period
		nt_idx = 6'(st_r.nt_wp[ch]
			- (nw[FREQ_BIT] ? NT_DLY_60 : NT_DLY_50));      // (R9)
		nt_old = nt_mem[ch][nt_idx];
		nt_sum = 25'(head.raw) + 25'(nt_old);
		xn     = cw[NOTCH_EN] ? nt_sum[24:1] : head.raw;       // (R4)

		// Moving average with stepwise length change
		target  = sgcr_avg_len(cw[AVG_LSB +: 5]);             // (R2) (R3)
		cur     = st_r.cur_len[ch];
		av_i1   = 10'(st_r.avg_wp[ch] - cur);
		av_i2   = 10'(av_i1 + 10'h001);
		cur_new = cur;
		sum_new = $signed(st_r.sum[ch]) + 34'(xn);
		if (cur == 10'h000 || (cur < target && st_r.ramp_due[ch]))
			cur_new = 10'(cur + 10'h001);                     // (R17)
		else if (cur > target && st_r.ramp_due[ch])
		begin
			cur_new = 10'(cur - 10'h001);                     // (R17)
			sum_new = sum_new - 34'(avg_mem[ch][av_i1])
				- 34'(avg_mem[ch][av_i2]);
		end
		else
			sum_new = sum_new - 34'(avg_mem[ch][av_i1]);
		avg_q   = sum_new / $signed({24'h000000, cur_new});
		avg_out = avg_q[23:0];

		// First-order low-pass
		lp_lvl  = (cw[LP_MODE_LSB +: 2] == LP_FIRST)
			? 4'({1'b0, cw[LP_LVL_LSB +: 3]} + 4'h1) : 4'h0; // (R5) (R6)
		lp_diff = 25'(avg_out) - 25'($signed(st_r.lp_y[ch]));
		lp_sh   = lp_diff >>> lp_lvl;                         // (R7)
		lp_add  = 25'($signed(st_r.lp_y[ch])) + lp_sh;
		lp_out  = (cur == 10'h000) ? avg_out : lp_add[23:0];  // (R7)

		// Range coding
		over  = head.raw == RAW_OVER;                         // (R10)
		under = head.raw < VALID_MIN;                         // (R11)
		res   = lp_out;
		if (lp_out > VALID_MAX)
			res = VALID_MAX;                                  // (R10)
		else if (lp_out < VALID_MIN)
			res = VALID_MIN;                                  // (R10)

		// Ramp requests: the divider tick wins over consumption
		st_nxt.ramp_due = st_r.ramp_due;
		if (pop)
			st_nxt.ramp_due[ch] = 1'b0;
		if (ramp_tick)
			st_nxt.ramp_due = '1;                             // (R17)

		// Result update for the channel at the buffer head
		if (pop)
		begin
			st_nxt.nt_wp[ch]  = 6'(st_r.nt_wp[ch] + 6'h01);
			st_nxt.avg_wp[ch] = 10'(st_r.avg_wp[ch] + 10'h001);
			st_nxt.last_ch    = ch;                           // (R19)
			st_nxt.stamp      = head.stamp;                   // (R21)
			if (ch == LAST_CH)
				st_nxt.cycles = 6'(st_r.cycles + 6'h01);      // (R20)
			if (head.err)
			begin
				st_nxt.value[ch]   = CODE_INVAL;              // (R14)
				st_nxt.flags[ch]   = 3'b101;                  // (R14) (R16)
				st_nxt.cur_len[ch] = 10'h000;                 // (R16)
				st_nxt.sum[ch]     = 34'h0;
				st_nxt.lp_y[ch]    = 24'h0;
			end
			else
			begin
				st_nxt.cur_len[ch] = cur_new;
				st_nxt.sum[ch]     = sum_new;
				st_nxt.lp_y[ch]    = lp_out;
				st_nxt.flags[ch][0] = 1'b0;                   // (R14)
				st_nxt.flags[ch][1] = over || under;          // (R15)
				st_nxt.flags[ch][2] = cur_new != target;      // (R16)
				if (over)
					st_nxt.value[ch] = CODE_OVER;             // (R10)
				else if (under)
					st_nxt.value[ch] = CODE_UNDER;            // (R11)
				else
					st_nxt.value[ch] = 32'(res);              // (R10)
			end
		end

		// Two-entry buffer from the shared converter
		if (pop)
			st_nxt.fifo[0] = st_r.fifo[1];
		if (push)
		begin                                                 // (R18)
			st_nxt.fifo[2'(st_r.fifo_cnt - {1'b0, pop})] = '{
				chan:  adc_channel,
				raw:   adc_raw,
				err:   !adc_checksum_ok || sensor_supply_fault
					|| io_supply_fault || !adc_configured,    // (R14)
				stamp: st_r.us_time                           // (R21)
			};
		end
		st_nxt.fifo_cnt = 2'(st_r.fifo_cnt + {1'b0, push}
			- {1'b0, pop});

		// Register writes, reserved bits dropped
		for (int i = 0; i < SLOTS; i++)
		begin                                                 // (R22)
			if (reg_req.wr && reg_req.addr == OFS_CTRL[i])
				st_nxt.ctrl[i] = reg_req.wdata[15:0] & CTRL_MASK;  // (R23)
			if (reg_req.wr && reg_req.addr == OFS_NOTCH[i])
				st_nxt.notch[i] = reg_req.wdata[15:0] & NOTCH_MASK; // (R23)
		end

		// Register reads
		st_nxt.rvalid = reg_req.rd;
		st_nxt.rdata  = 32'h0;
		if (reg_req.rd)
		begin
			for (int i = 0; i < SLOTS; i++)
			begin
				if (reg_req.addr == OFS_VALUE[i])
					st_nxt.rdata = st_r.value[i];
				if (reg_req.addr == OFS_FLAGS[i])
					st_nxt.rdata = {24'h0, st_r.flags[i],
						!adc_configured, 2'b00,               // (R14)
						excitation_overcurrent,               // (R13)
						io_supply_fault};                     // (R12)
			end
			if (reg_req.addr == OFS_CONV)
				st_nxt.rdata = {24'h0, st_r.cycles, st_r.last_ch}; // (R19) (R20)
			if (reg_req.addr == OFS_STAMP)
				st_nxt.rdata = st_r.stamp;                    // (R21)
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			st_r          <= '0;
			st_r.ctrl     <= {NUM_CH{WORD_RST}};               // (R24)
			st_r.notch    <= {NUM_CH{WORD_RST}};
			st_r.value    <= {NUM_CH{CODE_INVAL}};
			st_r.flags    <= {NUM_CH{3'b101}};
		end
		else
			st_r <= st_nxt;
	end

	// ------------------------------------------------------------
	// Sample histories, one per channel
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (mem_we)
		begin                                                 // (R24)
			nt_mem[ch][st_r.nt_wp[ch]]   <= head.raw;
			avg_mem[ch][st_r.avg_wp[ch]] <= xn;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign adc_ready  = st_r.fifo_cnt != 2'h2;
	assign reg_rdata  = st_r.rdata;
	assign reg_rvalid = st_r.rvalid;

	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			gauge_factor[i] = st_r.ctrl[i][FACTOR_LSB +: 3];  // (R1)
			notch_atten[i]  = st_r.notch[i][ATT_LSB +: 2];    // (R8)
		end
	end

endmodule // sgcr_readout
`default_nettype wire

/* tb/sgcr_adc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sgcr_adc_model
	import sgcr_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          adc_ready,
	output logic               adc_valid,
	output logic [1:0]         adc_channel,
	output logic signed [23:0] adc_raw,
	output logic               adc_checksum_ok
);
	initial
	begin
		adc_valid = 1'b0;
		adc_channel = 2'h0;
		adc_raw = 24'h000000;
		adc_checksum_ok = 1'b1;
	end

	// ------------------------------------------------------------
	// One sample, held until taken or for at most 21 cycles
	// ------------------------------------------------------------
	task automatic send(input logic [1:0] ch, input logic [23:0] raw,
		input logic ok, output logic done);
		done = 1'b0;
		@(negedge clk);
		adc_valid = 1'b1;
		adc_channel = ch;
		adc_raw = raw;
		adc_checksum_ok = ok;
		for (int n = 0; n < 20 && !done; n++)
		begin
			done = adc_ready;
			@(posedge clk);
			if (!done)
				@(negedge clk);
		end
		@(negedge clk);
		adc_valid = 1'b0;
		adc_channel = ~ch;
		adc_raw = ~raw;
		adc_checksum_ok = ~ok;
	endtask
endmodule // sgcr_adc_model
`default_nettype wire

/* tb/sgcr_readout_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sgcr_readout_asserts
	import sgcr_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   reset,
	input wire sgcr_req_s              reg_req,
	input wire logic [31:0]            reg_rdata,
	input wire logic                   reg_rvalid,
	input wire logic                   adc_ready,
	input wire logic                   adc_configured,
	input wire logic                   io_supply_fault,
	input wire logic                   excitation_overcurrent,
	input wire logic [NUM_CH-1:0][2:0] gauge_factor,
	input wire logic [NUM_CH-1:0][1:0] notch_atten
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	sequence rd_flags;
		reg_req.rd && reg_req.addr == OFS_FLAGS[0];
	endsequence
	sequence wr_ctrl;
		reg_req.wr && reg_req.addr == OFS_CTRL[0];
	endsequence
	sequence inputs_still;
		$stable(io_supply_fault) && $stable(excitation_overcurrent)
			&& $stable(adc_configured);
	endsequence

	read_answer_a: assert property (reg_req.rd |=> reg_rvalid)
		else $error("read not answered");
	no_answer_a: assert property (!reg_req.rd |=> !reg_rvalid)
		else $error("answer without read");
	idle_zero_a: assert property (!reg_rvalid |-> reg_rdata == 32'h0)
		else $error("read data not zero while idle");
	factor_wr_a: assert property (wr_ctrl |=>
		gauge_factor[0] == $past(reg_req.wdata[2:0]))
		else $error("factor not taken from write");
	factor_hold_a: assert property (
		!(reg_req.wr && reg_req.addr == OFS_CTRL[1])
		|=> $stable(gauge_factor[1]))
		else $error("factor changed without write");
	atten_wr_a: assert property (
		reg_req.wr && reg_req.addr == OFS_NOTCH[0]
		|=> notch_atten[0] == $past(reg_req.wdata[13:12]))
		else $error("attenuation not taken from write");
	ready_back_a: assert property (!adc_ready && !reg_req.wr |=> adc_ready)
		else $error("buffer did not drain");
	flags_live_a: assert property (rd_flags ##0 inputs_still |=>
		reg_rdata[1:0] == $past({excitation_overcurrent, io_supply_fault})
		&& reg_rdata[4] == !$past(adc_configured))
		else $error("live flags wrong");
	wo_read_a: assert property (
		reg_req.rd && reg_req.addr == OFS_CTRL[0] |=> reg_rdata == 32'h0)
		else $error("write-only register readable");
endmodule // sgcr_readout_asserts

bind sgcr_readout sgcr_readout_asserts u_chk (.clk(clk), .reset(reset),
	.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.adc_ready(adc_ready), .adc_configured(adc_configured),
	.io_supply_fault(io_supply_fault),
	.excitation_overcurrent(excitation_overcurrent),
	.gauge_factor(gauge_factor), .notch_atten(notch_atten));
`default_nettype wire

/* tb/strain_gauge_channel_readout_test.sv */
`timescale 1ns/1ps
`default_nettype none
module strain_gauge_channel_readout_test
	import sgcr_pkg::*;
;
	logic                   clk = 1'b0;
	logic                   reset = 1'b1;
	sgcr_req_s              reg_req = '0;
	logic [31:0]            reg_rdata, d;
	logic                   reg_rvalid, adc_valid, adc_ready, adc_checksum_ok;
	logic [1:0]             adc_channel;
	logic signed [23:0]     adc_raw;
	logic                   adc_configured = 1'b0;
	logic                   io_supply_fault = 1'b0;
	logic                   sensor_supply_fault = 1'b0;
	logic                   excitation_overcurrent = 1'b0;
	logic [NUM_CH-1:0][2:0] gauge_factor;
	logic [NUM_CH-1:0][1:0] notch_atten;
	int                     n_errors = 0;
	int                     n_tests = 0;

	always #50 clk = ~clk;

	sgcr_readout dut (.clk(clk), .reset(reset), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.adc_valid(adc_valid), .adc_ready(adc_ready),
		.adc_channel(adc_channel), .adc_raw(adc_raw),
		.adc_checksum_ok(adc_checksum_ok), .adc_configured(adc_configured),
		.io_supply_fault(io_supply_fault),
		.sensor_supply_fault(sensor_supply_fault),
		.excitation_overcurrent(excitation_overcurrent),
		.gauge_factor(gauge_factor), .notch_atten(notch_atten));
	sgcr_adc_model u_adc (.clk(clk), .adc_ready(adc_ready),
		.adc_valid(adc_valid), .adc_channel(adc_channel),
		.adc_raw(adc_raw), .adc_checksum_ok(adc_checksum_ok));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic finish_test();
		if (n_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] v);
		@(negedge clk);
		reg_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: {16'h0000, v}};
		@(negedge clk);
		reg_req.wr = 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, output logic [31:0] v);
		@(negedge clk);
		reg_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
		@(negedge clk);
		reg_req.rd = 1'b0;
		v = reg_rdata;
	endtask
	task automatic snd(input logic [1:0] ch, input logic [23:0] raw,
		input logic ok);
		logic done;
		u_adc.send(ch, raw, ok, done);
		chk(32'(done), 32'h1);
		if (!done)
			finish_test();
		repeat (2) @(negedge clk);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rd(OFS_VALUE[0], d);
		chk(d, CODE_INVAL);
		rd(OFS_FLAGS[0], d);
		chk(d, 32'h000000B0);
		rd(OFS_CONV, d);
		chk(d, 32'h0);
		rd(OFS_CTRL[0], d);
		chk(d, 32'h0);
		rd(10'h3FF, d);
		chk(d, 32'h0);
	endtask
	task automatic t_values();
		logic [23:0] raw [4] = '{24'h000064, 24'h7FFFFF, 24'h800001, 24'hFFFFFB};
		logic [31:0] exp [4] = '{32'h64, CODE_OVER, CODE_UNDER, 32'hFFFFFFFB};
		logic [31:0] flg [4] = '{32'h00, 32'h40, 32'h40, 32'h00};
		adc_configured = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			snd(2'(i), raw[i], 1'b1);
			rd(OFS_VALUE[i], d);
			chk(d, exp[i]);
			rd(OFS_FLAGS[i], d);
			chk(d & 32'h60, flg[i]);
		end
		rd(OFS_CONV, d);
		chk(d, 32'h07);
	endtask
	task automatic t_faults();
		snd(2'h0, 24'h000010, 1'b0);
		rd(OFS_VALUE[0], d);
		chk(d, CODE_INVAL);
		rd(OFS_FLAGS[0], d);
		chk(d & 32'h20, 32'h20);
		io_supply_fault = 1'b1;
		excitation_overcurrent = 1'b1;
		adc_configured = 1'b0;
		rd(OFS_FLAGS[1], d);
		chk(d & 32'h13, 32'h13);
		snd(2'h1, 24'h000010, 1'b1);
		rd(OFS_VALUE[1], d);
		chk(d, CODE_INVAL);
		io_supply_fault = 1'b0;
		excitation_overcurrent = 1'b0;
		adc_configured = 1'b1;
		sensor_supply_fault = 1'b1;
		snd(2'h2, 24'h000010, 1'b1);
		rd(OFS_VALUE[2], d);
		chk(d, CODE_INVAL);
		sensor_supply_fault = 1'b0;
		rd(OFS_FLAGS[2], d);
		chk(d & 32'h13, 32'h00);
	endtask
	task automatic t_ctrl();
		for (int i = 0; i < 8; i++)
		begin
			wr(OFS_CTRL[1], 16'(i) | 16'h8200);
			chk(32'(gauge_factor[1]), i);
		end
		for (int i = 0; i < 3; i++)
		begin
			wr(OFS_NOTCH[2], 16'(i << 12) | 16'h4FFF);
			chk(32'(notch_atten[2]), i);
		end
		wr(OFS_NOTCH[0], 16'h1000);
		chk(32'(notch_atten[0]), 32'h1);
		chk(32'({gauge_factor[0], gauge_factor[3], notch_atten[3]}), 0);
	endtask
	task automatic t_stall();
		logic seen;
		logic done;
		seen = 1'b0;
		fork
			for (int i = 0; i < 3; i++)
				u_adc.send(2'(i), 24'(i + 7), 1'b1, done);
			begin
				@(negedge clk);
				reg_req = '{rd: 1'b0, wr: 1'b1, addr: OFS_VALUE[0], wdata: 32'h0};
				repeat (8)
				begin
					@(negedge clk);
					seen |= !adc_ready;
				end
				reg_req.wr = 1'b0;
			end
		join
		chk(32'({seen, done}), 32'h3);
		repeat (2) @(negedge clk);
		for (int i = 0; i < 3; i++)
		begin
			rd(OFS_VALUE[i], d);
			chk(d, 32'(i + 7));
		end
	endtask
	task automatic t_ramp();
		snd(2'h0, 24'h0003E8, 1'b1);
		wr(OFS_CTRL[0], 16'h0008);
		snd(2'h0, 24'h0003E8, 1'b1);
		rd(OFS_FLAGS[0], d);
		chk(d & 32'h80, 32'h80);
		rd(OFS_VALUE[0], d);
		chk(d, 32'h3E8);
		repeat (RAMP_CY_I + 100) @(negedge clk);
		snd(2'h0, 24'h0003E8, 1'b1);
		snd(2'h0, 24'h0003E8, 1'b1);
		rd(OFS_FLAGS[0], d);
		chk(d & 32'h80, 32'h0);
	endtask
	task automatic t_lowpass();
		wr(OFS_CTRL[3], 16'h0400);
		snd(2'h3, 24'h0003E8, 1'b1);
		rd(OFS_VALUE[3], d);
		chk(d, 32'h000001F1);
		wr(OFS_CTRL[3], 16'h0C00);
		snd(2'h3, 24'h000010, 1'b1);
		rd(OFS_VALUE[3], d);
		chk(d, 32'h00000010);
	endtask

	initial
	begin
		repeat (10) @(negedge clk);
		reset = 1'b0;
		t_reset();
		t_values();
		t_faults();
		t_ctrl();
		t_stall();
		t_ramp();
		t_lowpass();
		finish_test();
	end
endmodule // strain_gauge_channel_readout_test
`default_nettype wire
